// >>> priority_control_5_pkg.sv
// priority_control_5_pkg: offsets, field layout, reset values and level codes
// for the priority control 5 register block; shared by all design files.
package priority_control_5_pkg;
  localparam int ADDR_W        = 4;
  localparam int DATA_W        = 16;
  localparam int PRIO_W        = 3;
  localparam int NUM_SRC       = 4;
  localparam logic [ADDR_W-1:0] PRIO_CTRL5_OFS = 4'h0;
  // field low bit positions
  localparam int CAP8_LSB      = 12;
  localparam int CAP7_LSB      = 8;
  localparam int CONV2_LSB     = 4;
  localparam int EXT1_LSB      = 0;
  // source indices
  localparam int SRC_EXT1      = 0;
  localparam int SRC_CONV2     = 1;
  localparam int SRC_CAP7      = 2;
  localparam int SRC_CAP8      = 3;
  // level codes
  localparam logic [PRIO_W-1:0] LEVEL_OFF  = 3'h0;
  localparam logic [PRIO_W-1:0] LEVEL_MIN  = 3'h1;
  localparam logic [PRIO_W-1:0] LEVEL_MAX  = 3'h7;
  localparam logic [PRIO_W-1:0] FIELD_RST  = 3'h4;
  localparam logic [DATA_W-1:0] REG_RST    = 16'h4444;
  localparam logic [DATA_W-1:0] IMPL_MASK  = 16'h7777;
endpackage

// >>> priority_control_5_prio_field.sv
// priority_control_5_prio_field: one 3-bit priority field with its level decode.
// assumes a synchronous active-low reset and a one-cycle write strobe.
`timescale 1ns/10ps
module priority_control_5_prio_field
(
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst_b,
  // write side
  input  wire logic                        wrEn,
  input  wire logic [priority_control_5_pkg::PRIO_W-1:0] wrData,
  // source request
  input  wire logic                        srcReq,
  // outputs
  output logic      [priority_control_5_pkg::PRIO_W-1:0] fieldVal,
  output logic      [priority_control_5_pkg::PRIO_W-1:0] reqLevel
);
  import priority_control_5_pkg::*;

  logic [PRIO_W-1:0] field_ff;
  logic [PRIO_W-1:0] nxt_field;

  // next field value
  assign nxt_field = wrEn ? wrData : field_ff;

  // field storage, reset to level four
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      field_ff <= FIELD_RST;
    else
      field_ff <= nxt_field;
  end

  // code equals level; zero masks the source entirely
  assign fieldVal = field_ff;
  assign reqLevel = (srcReq && field_ff != LEVEL_OFF) ? field_ff : LEVEL_OFF;
endmodule

// >>> priority_control_5_prio_ctrl.sv
// priority_control_5_prio_ctrl: priority control 5 register with four source fields.
// assumes a plain strobe register port; read data follow one cycle later.
//
// Contract
// - unimplemented bits 15, 11, 7, 3 read zero and ignore writes.
// - capture channel 8 priority field sits in bits 14 to 12.
// - capture channel 7 priority field sits in bits 10 to 8.
// - field code 7 gives its source level seven, the highest.
// - field code 1 gives level one; codes two to six map linearly.
// - field code 0 never takes or presents its source.
// - converter 2 done priority field sits in bits 6 to 4.
//
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/10ps
module priority_control_5_prio_ctrl
(
  // clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst_b,
  // register port
  input  wire logic [priority_control_5_pkg::ADDR_W-1:0]  regAddr,
  input  wire logic [priority_control_5_pkg::DATA_W-1:0]  regWrData,
  input  wire logic                         regWrEn,
  input  wire logic                         regRdEn,
  output logic      [priority_control_5_pkg::DATA_W-1:0]  regRdData,
  // source requests: [0] ext1, [1] conv2, [2] cap7, [3] cap8
  input  wire logic [priority_control_5_pkg::NUM_SRC-1:0] srcReq,
  // field values to the arbiter
  output logic      [priority_control_5_pkg::PRIO_W-1:0]  capture8_priority,
  output logic      [priority_control_5_pkg::PRIO_W-1:0]  capture7_priority,
  output logic      [priority_control_5_pkg::PRIO_W-1:0]  converter2_done_priority,
  output logic      [priority_control_5_pkg::PRIO_W-1:0]  external_irq1_priority,
  // masked per-source levels, zero when not presented
  output logic      [priority_control_5_pkg::PRIO_W-1:0]  cap8Level,
  output logic      [priority_control_5_pkg::PRIO_W-1:0]  cap7Level,
  output logic      [priority_control_5_pkg::PRIO_W-1:0]  conv2Level,
  output logic      [priority_control_5_pkg::PRIO_W-1:0]  ext1Level
);
  import priority_control_5_pkg::*;

  logic              hitReg;
  logic              wrHit;
  logic [DATA_W-1:0] regView;
  logic [DATA_W-1:0] rdData_ff;
  logic [DATA_W-1:0] nxt_rdData;

  // address decode; unmapped reads return zero
  assign hitReg     = (regAddr == PRIO_CTRL5_OFS);
  assign wrHit      = regWrEn && hitReg;
  assign nxt_rdData = (regRdEn && hitReg) ? regView : 16'h0000;

  // one instance per source; write data slices ignore the spare bits
  priority_control_5_prio_field u_cap8 (
    .clk      (clk),
    .rst_b    (rst_b),
    .wrEn     (wrHit),
    .wrData   (regWrData[CAP8_LSB +: PRIO_W]),
    .srcReq   (srcReq[SRC_CAP8]),
    .fieldVal (capture8_priority),
    .reqLevel (cap8Level)
  );
  priority_control_5_prio_field u_cap7 (
    .clk      (clk),
    .rst_b    (rst_b),
    .wrEn     (wrHit),
    .wrData   (regWrData[CAP7_LSB +: PRIO_W]),
    .srcReq   (srcReq[SRC_CAP7]),
    .fieldVal (capture7_priority),
    .reqLevel (cap7Level)
  );
  priority_control_5_prio_field u_conv2 (
    .clk      (clk),
    .rst_b    (rst_b),
    .wrEn     (wrHit),
    .wrData   (regWrData[CONV2_LSB +: PRIO_W]),
    .srcReq   (srcReq[SRC_CONV2]),
    .fieldVal (converter2_done_priority),
    .reqLevel (conv2Level)
  );
  priority_control_5_prio_field u_ext1 (
    .clk      (clk),
    .rst_b    (rst_b),
    .wrEn     (wrHit),
    .wrData   (regWrData[EXT1_LSB +: PRIO_W]),
    .srcReq   (srcReq[SRC_EXT1]),
    .fieldVal (external_irq1_priority),
    .reqLevel (ext1Level)
  );

  // register view; spare top bit of every nibble held at zero
  assign regView = {1'b0, capture8_priority, 1'b0, capture7_priority,
                    1'b0, converter2_done_priority, 1'b0, external_irq1_priority};

  // read data register, valid only the cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      rdData_ff <= 16'h0000;
    else
      rdData_ff <= nxt_rdData;
  end
  assign regRdData = rdData_ff;

  // checks on the register port and on the level outputs;
  // the arbiter trusts these outputs blindly, so they are guarded here
  property p_spare_zero;
    @(posedge clk) disable iff (!rst_b)
      (regRdData & ~IMPL_MASK) == 16'h0000;
  endproperty
  a_spare_zero: assert property (p_spare_zero) else $error("spare bit read nonzero");

  property p_cap8_write;
    @(posedge clk) disable iff (!rst_b)
      wrHit |=> capture8_priority == $past(regWrData[14:12]);
  endproperty
  a_cap8_write: assert property (p_cap8_write) else $error("cap8 field not written");

  property p_cap7_read;
    @(posedge clk) disable iff (!rst_b)
      (regRdEn && hitReg) |=> regRdData[10:8] == $past(capture7_priority);
  endproperty
  a_cap7_read: assert property (p_cap7_read) else $error("cap7 field read wrong");

  property p_level_max;
    @(posedge clk) disable iff (!rst_b)
      (srcReq[SRC_CAP8] && capture8_priority == LEVEL_MAX) |-> cap8Level == 3'h7;
  endproperty
  a_level_max: assert property (p_level_max) else $error("code 7 not level 7");

  property p_level_linear;
    @(posedge clk) disable iff (!rst_b)
      (srcReq[SRC_CAP7] && capture7_priority != LEVEL_OFF) |-> cap7Level == capture7_priority;
  endproperty
  a_level_linear: assert property (p_level_linear) else $error("level not linear");

  property p_off_masks;
    @(posedge clk) disable iff (!rst_b)
      (conv2Level != LEVEL_OFF) |-> (srcReq[SRC_CONV2] && converter2_done_priority != LEVEL_OFF);
  endproperty
  a_off_masks: assert property (p_off_masks) else $error("disabled source presented");

  property p_conv2_write;
    @(posedge clk) disable iff (!rst_b)
      wrHit ##1 (regRdEn && hitReg) |=> regRdData[6:4] == $past(regWrData[6:4], 2);
  endproperty
  a_conv2_write: assert property (p_conv2_write) else $error("conv2 field round trip");

  // reset checks run without a disable, so the reset cycle itself is covered
  property p_reset_val;
    @(posedge clk)
      !rst_b |=> regView == REG_RST;
  endproperty
  a_reset_val: assert property (p_reset_val) else $error("reset value wrong");

  property p_reset_fields;
    @(posedge clk)
      !rst_b |=> (capture8_priority == FIELD_RST && capture7_priority == FIELD_RST &&
        converter2_done_priority == FIELD_RST && external_irq1_priority == FIELD_RST);
  endproperty
  a_reset_fields: assert property (p_reset_fields) else $error("field reset wrong");

  property p_reset_rd;
    @(posedge clk)
      !rst_b |=> regRdData == 16'h0000;
  endproperty
  a_reset_rd: assert property (p_reset_rd) else $error("read data not cleared");

  // spare bits: the stored word is the written word with spares dropped
  property p_spare_wr_ignored;
    @(posedge clk) disable iff (!rst_b)
      wrHit |=> regView == ($past(regWrData) & IMPL_MASK);
  endproperty
  a_spare_wr_ignored: assert property (p_spare_wr_ignored) else $error("spare written");

  property p_rd_word;
    @(posedge clk) disable iff (!rst_b)
      (regRdEn && hitReg) |=> regRdData == $past(regView);
  endproperty
  a_rd_word: assert property (p_rd_word) else $error("read word wrong");

  // field placement: each field takes its own slice and holds between writes;
  // a field that moves without a write would silently reorder the arbiter
  property p_cap8_hold;
    @(posedge clk) disable iff (!rst_b)
      !wrHit |=> $stable(capture8_priority);
  endproperty
  a_cap8_hold: assert property (p_cap8_hold) else $error("cap8 field moved");

  property p_cap8_read;
    @(posedge clk) disable iff (!rst_b)
      (regRdEn && hitReg) |=> regRdData[CAP8_LSB +: PRIO_W] == $past(capture8_priority);
  endproperty
  a_cap8_read: assert property (p_cap8_read) else $error("cap8 field read wrong");

  property p_cap7_write;
    @(posedge clk) disable iff (!rst_b)
      wrHit |=> capture7_priority == $past(regWrData[CAP7_LSB +: PRIO_W]);
  endproperty
  a_cap7_write: assert property (p_cap7_write) else $error("cap7 field not written");

  property p_cap7_hold;
    @(posedge clk) disable iff (!rst_b)
      !wrHit |=> $stable(capture7_priority);
  endproperty
  a_cap7_hold: assert property (p_cap7_hold) else $error("cap7 field moved");

  property p_conv2_land;
    @(posedge clk) disable iff (!rst_b)
      wrHit |=> converter2_done_priority == $past(regWrData[CONV2_LSB +: PRIO_W]);
  endproperty
  a_conv2_land: assert property (p_conv2_land) else $error("conv2 field not written");

  property p_conv2_hold;
    @(posedge clk) disable iff (!rst_b)
      !wrHit |=> $stable(converter2_done_priority);
  endproperty
  a_conv2_hold: assert property (p_conv2_hold) else $error("conv2 field moved");

  property p_conv2_read;
    @(posedge clk) disable iff (!rst_b)
      (regRdEn && hitReg) |=> regRdData[CONV2_LSB +: PRIO_W] == $past(converter2_done_priority);
  endproperty
  a_conv2_read: assert property (p_conv2_read) else $error("conv2 field read wrong");

  // level encoding: code equals level, so the arbiter compares fields directly
  property p_cap7_max;
    @(posedge clk) disable iff (!rst_b)
      (srcReq[SRC_CAP7] && capture7_priority == LEVEL_MAX) |-> cap7Level == 3'h7;
  endproperty
  a_cap7_max: assert property (p_cap7_max) else $error("cap7 code 7 not level 7");

  property p_conv2_max;
    @(posedge clk) disable iff (!rst_b)
      (srcReq[SRC_CONV2] && converter2_done_priority == LEVEL_MAX) |-> conv2Level == 3'h7;
  endproperty
  a_conv2_max: assert property (p_conv2_max) else $error("conv2 code 7 not level 7");

  property p_ext1_max;
    @(posedge clk) disable iff (!rst_b)
      (srcReq[SRC_EXT1] && external_irq1_priority == LEVEL_MAX) |-> ext1Level == 3'h7;
  endproperty
  a_ext1_max: assert property (p_ext1_max) else $error("ext1 code 7 not level 7");

  property p_cap8_linear;
    @(posedge clk) disable iff (!rst_b)
      (srcReq[SRC_CAP8] && capture8_priority != LEVEL_OFF) |-> cap8Level == capture8_priority;
  endproperty
  a_cap8_linear: assert property (p_cap8_linear) else $error("cap8 level not linear");

  property p_conv2_linear;
    @(posedge clk) disable iff (!rst_b)
      (srcReq[SRC_CONV2] && converter2_done_priority != LEVEL_OFF) |->
        conv2Level == converter2_done_priority;
  endproperty
  a_conv2_linear: assert property (p_conv2_linear) else $error("conv2 level not linear");

  property p_ext1_linear;
    @(posedge clk) disable iff (!rst_b)
      (srcReq[SRC_EXT1] && external_irq1_priority != LEVEL_OFF) |->
        ext1Level == external_irq1_priority;
  endproperty
  a_ext1_linear: assert property (p_ext1_linear) else $error("ext1 level not linear");

  // lowest enabled code must still present its source at level one
  property p_cap8_min;
    @(posedge clk) disable iff (!rst_b)
      (srcReq[SRC_CAP8] && capture8_priority == LEVEL_MIN) |-> cap8Level == 3'h1;
  endproperty
  a_cap8_min: assert property (p_cap8_min) else $error("cap8 code 1 not level 1");

  property p_cap7_min;
    @(posedge clk) disable iff (!rst_b)
      (srcReq[SRC_CAP7] && capture7_priority == LEVEL_MIN) |-> cap7Level == 3'h1;
  endproperty
  a_cap7_min: assert property (p_cap7_min) else $error("cap7 code 1 not level 1");

  property p_conv2_min;
    @(posedge clk) disable iff (!rst_b)
      (srcReq[SRC_CONV2] && converter2_done_priority == LEVEL_MIN) |-> conv2Level == 3'h1;
  endproperty
  a_conv2_min: assert property (p_conv2_min) else $error("conv2 code 1 not level 1");

  property p_ext1_min;
    @(posedge clk) disable iff (!rst_b)
      (srcReq[SRC_EXT1] && external_irq1_priority == LEVEL_MIN) |-> ext1Level == 3'h1;
  endproperty
  a_ext1_min: assert property (p_ext1_min) else $error("ext1 code 1 not level 1");

  // disabled fields: a zero code hides the source even while it requests
  property p_cap8_off;
    @(posedge clk) disable iff (!rst_b)
      (capture8_priority == LEVEL_OFF || !srcReq[SRC_CAP8]) |-> cap8Level == LEVEL_OFF;
  endproperty
  a_cap8_off: assert property (p_cap8_off) else $error("cap8 presented while off");

  property p_cap7_off;
    @(posedge clk) disable iff (!rst_b)
      (capture7_priority == LEVEL_OFF || !srcReq[SRC_CAP7]) |-> cap7Level == LEVEL_OFF;
  endproperty
  a_cap7_off: assert property (p_cap7_off) else $error("cap7 presented while off");

  property p_ext1_off;
    @(posedge clk) disable iff (!rst_b)
      (external_irq1_priority == LEVEL_OFF || !srcReq[SRC_EXT1]) |-> ext1Level == LEVEL_OFF;
  endproperty
  a_ext1_off: assert property (p_ext1_off) else $error("ext1 presented while off");

  property p_no_req_zero;
    @(posedge clk) disable iff (!rst_b)
      (srcReq == 4'h0) |-> (cap8Level | cap7Level | conv2Level | ext1Level) == LEVEL_OFF;
  endproperty
  a_no_req_zero: assert property (p_no_req_zero) else $error("level without request");
endmodule

// >>> priority_control_5_prio_ctrl_tb.sv
// priority_control_5_prio_ctrl_tb: self-checking bench for the priority control 5 register.
// assumes read data stand one cycle after the strobe; bench drives every port.
`timescale 1ns/10ps
`define CHK(nm, e, g) \
  begin \
    num_checks++; \
    if ((g) !== (e)) \
    begin \
      fail_count++; \
      $display("ERROR %s expected %h seen %h", nm, e, g); \
    end \
  end
module priority_control_5_prio_ctrl_tb;
  import priority_control_5_pkg::*;
  logic              clk = 1'b0;
  logic              rst_b;
  logic [ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0] regWrData;
  logic              regWrEn;
  logic              regRdEn;
  logic [DATA_W-1:0] regRdData;
  logic [NUM_SRC-1:0] srcReq;
  logic [PRIO_W-1:0] cap8P, cap7P, conv2P, ext1P, cap8L, cap7L, conv2L, ext1L;
  logic [DATA_W-1:0] rdVal;
  logic [PRIO_W-1:0] code;
  int                fail_count = 0;
  int                num_checks = 0;
  int                cycles     = 0;

  priority_control_5_prio_ctrl dut_u (.clk(clk), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .srcReq(srcReq),
    .capture8_priority(cap8P), .capture7_priority(cap7P),
    .converter2_done_priority(conv2P), .external_irq1_priority(ext1P),
    .cap8Level(cap8L), .cap7Level(cap7L), .conv2Level(conv2L), .ext1Level(ext1L));

  // 50 ns period
  always #25 clk = ~clk;

  // hang guard, far above the roughly 70 cycles the tests need
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fail_count++;
      final_report();
    end
  end

  task automatic final_report();
    if (fail_count == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // write taken at the next edge; strobe left up so calls may follow back to back
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    regAddr   <= a;
    regWrData <= d;
    regWrEn   <= 1'b1;
    regRdEn   <= 1'b0;
    @(posedge clk);
  endtask

  // both strobes low for one cycle
  task automatic idle();
    regWrEn <= 1'b0;
    regRdEn <= 1'b0;
    @(posedge clk);
  endtask

  // read data sampled mid-cycle in the one cycle they stand
  task automatic rd(input logic [ADDR_W-1:0] a);
    regAddr <= a;
    regWrEn <= 1'b0;
    regRdEn <= 1'b1;
    @(posedge clk);
    regRdEn <= 1'b0;
    @(negedge clk);
    rdVal = regRdData;
    @(posedge clk);
  endtask

  task automatic chk_fields(input logic [DATA_W-1:0] v);
    @(negedge clk);
    `CHK("cap8 field", v[14:12], cap8P)
    `CHK("cap7 field", v[10:8], cap7P)
    `CHK("conv2 field", v[6:4], conv2P)
    `CHK("ext1 field", v[2:0], ext1P)
    @(posedge clk);
  endtask

  // a raised request shows its code, code zero never shows
  task automatic chk_levels(input logic [NUM_SRC-1:0] req);
    srcReq <= req;
    @(negedge clk);
    `CHK("cap8 level", req[3] ? code : 3'h0, cap8L)
    `CHK("cap7 level", req[2] ? code : 3'h0, cap7L)
    `CHK("conv2 level", req[1] ? code : 3'h0, conv2L)
    `CHK("ext1 level", req[0] ? code : 3'h0, ext1L)
    @(posedge clk);
  endtask

  initial
  begin
    rst_b = 1'b0;
    regAddr = '0;
    regWrData = '0;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    srcReq = '0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    rd(PRIO_CTRL5_OFS);
    `CHK("reset word", REG_RST, rdVal)
    chk_fields(REG_RST);
    wr(PRIO_CTRL5_OFS, 16'hFFFF);
    rd(PRIO_CTRL5_OFS);
    `CHK("spare bits", 16'h7777, rdVal)
    wr(PRIO_CTRL5_OFS, 16'h7123);
    rd(PRIO_CTRL5_OFS);
    `CHK("word", 16'h7123, rdVal)
    // read data stand one cycle only, then fall back to zero
    @(negedge clk);
    `CHK("idle read data", 16'h0000, regRdData)
    @(posedge clk);
    chk_fields(16'h7123);
    // unmapped place: writes dropped, reads zero
    wr(4'h1, 16'h1111);
    rd(4'h1);
    `CHK("unmapped read", 16'h0000, rdVal)
    rd(PRIO_CTRL5_OFS);
    `CHK("after unmapped", 16'h7123, rdVal)
    // every level code on every source
    for (int i = 0; i < 8; i++)
    begin
      code = i[2:0];
      wr(PRIO_CTRL5_OFS, {4{1'b0, code}});
      idle();
      chk_levels(4'hF);
      chk_levels(4'h5);
    end
    // reset in mid-run restores level four
    rst_b <= 1'b0;
    @(posedge clk);
    rst_b <= 1'b1;
    rd(PRIO_CTRL5_OFS);
    `CHK("second reset", REG_RST, rdVal)
    code = FIELD_RST;
    chk_levels(4'hA);
    final_report();
  end
endmodule
